// ==== pkg/emcs_pkg.sv ====
// Shared constants for the MAC configuration and status block
package emcs_pkg;
	// Register offsets on the local bus
	localparam logic [4:0] ADDR_TX_STATUS = 5'h04;
	localparam logic [4:0] ADDR_RX_CFG_STS = 5'h0c;
	localparam logic [4:0] ADDR_TX_CONFIG = 5'h0d;
	localparam logic [4:0] ADDR_DATA_CONFIG = 5'h0e;
	localparam logic [4:0] ADDR_IRQ_MASK = 5'h0f;
	localparam logic [4:0] ADDR_GAP_PART1 = 5'h12;
	localparam logic [4:0] ADDR_GAP_PART2 = 5'h13;
	localparam logic [4:0] ADDR_GAP_LENGTH = 5'h16;
	// Reset values
	localparam logic [7:0] RST_IRQ_MASK = 8'h00;
	localparam logic [7:0] RST_DATA_CONFIG = 8'h00;
	localparam logic [7:0] RST_TX_CONFIG = 8'h00;
	localparam logic [7:0] RST_RX_CONFIG = 8'h40;
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [6:0] RST_GAP_LENGTH = 7'h15;
	localparam logic [6:0] RST_GAP_PART1 = 7'h0c;
	localparam logic [6:0] RST_GAP_PART2 = 7'h12;
	// Register widths and field positions
	localparam int IRQ_BITS = 7;
	localparam int GAP_BITS = 7;
	localparam int DC_WORD_WIDE = 0;
	localparam int DC_DMA_FORCE_DONE = 7;
	localparam int TC_FULL_DUPLEX = 7;
	localparam int TC_PAD_DISABLE = 6;
	localparam int TC_LATE_COLL_RETRY = 5;
	localparam int TC_LOOPBACK_HI = 2;
	localparam int TC_LOOPBACK_LO = 1;
	localparam int TC_CRC_INHIBIT = 0;
	localparam int TS_LATE_COLLISION = 7;
	localparam int TS_TX_GAVE_UP = 3;
	localparam int TS_COLLIDED = 2;
	localparam int TS_TX_OK = 0;
	localparam int RC_IRQ_POLARITY = 6;
	localparam int RC_CHECK_ONLY = 5;
	localparam int RC_ALL_UNICAST = 4;
	localparam int RC_MULTICAST = 3;
	localparam int RC_BROADCAST = 2;
	localparam int RC_SHORT_FRAMES = 1;
	localparam int RC_SAVE_ERRORS = 0;
	// Loopback encodings
	localparam logic [1:0] LOOP_MAC = 2'h1;
	localparam logic [1:0] LOOP_PHY = 2'h2;
	// Destination address kinds from the receive parser
	localparam logic [1:0] DST_UNICAST = 2'h0;
	localparam logic [1:0] DST_MULTICAST = 2'h1;
	localparam logic [1:0] DST_BROADCAST = 2'h2;
	// Frame shaping
	localparam logic [5:0] MIN_FRAME_BYTES = 6'h3c;
	localparam logic [1:0] FCS_LAST_IDX = 2'h3;
	localparam logic [31:0] CRC_POLY = 32'hedb8_8320;
	localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
	typedef enum logic [1:0] {EMCS_TX_DATA, EMCS_TX_PAD, EMCS_TX_FCS} emcs_tx_state_e;
endpackage

// ==== hw/emcs_top.sv ====
// Configuration, status, frame shaping and receive filter of the MAC
//
// Notes on behaviour
// - Seven interrupt enables, all reset disabled.
// - Interrupt only for set and enabled flags.
// - data_config bit 0 selects word-wide DMA.
// - data_config bit 7 forces DMA complete.
// - tx_config bit 7 selects full duplex.
// - Pad short frames unless pad disabled.
// - tx_config bit 5 retries late collisions.
// - tx_config bits 2:1 select loopback mode.
// - tx_config bit 0 inhibits appended CRC.
// - tx_status bit 3 flags excessive-collision abort.
// - tx_status bit 2 flags any collision.
// - tx_status bit 7 late, bit 0 ok.
// - rx_config bit 6 sets interrupt polarity.
// - Check-only mode never stores frames.
// - Accept every unicast that passes the short and error checks when bit 4 set.
// - Multicast accepted only through hash hit.
// - Bit 2 broadcast, bit 1 short frames.
// - Bit 0 keeps frames with errors.
// - rx_status reports seven receive conditions.
// - Offset 0CH writes config, reads status.
// - gap_length seven bits, reset 15H.
// - gap_part1 seven bits, reset 0cH.
// - gap_part2 seven bits, reset 12H.
`timescale 1ns/1ps
module emcs_top (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_cs,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [4:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	input wire logic i_isa_mode,
	input wire logic [6:0] i_irq_status,
	output logic o_irq,
	input wire logic i_dma_done,
	output logic o_dma_complete,
	output logic o_word_wide,
	output logic o_full_duplex,
	output logic o_late_coll_retry,
	output logic [1:0] o_loopback_sel,
	output logic o_mac_loopback,
	output logic o_phy_loopback,
	output logic [6:0] o_gap_length,
	output logic [6:0] o_gap_part1,
	output logic [6:0] o_gap_part2,
	input wire logic i_tx_start,
	input wire logic i_tx_ok,
	input wire logic i_tx_collided,
	input wire logic i_tx_gave_up,
	input wire logic i_tx_late_collision,
	input wire logic i_tx_valid,
	input wire logic [7:0] i_tx_data,
	input wire logic i_tx_last,
	output logic o_tx_ready,
	output logic o_txo_valid,
	output logic [7:0] o_txo_data,
	output logic o_txo_last,
	input wire logic i_txo_ready,
	input wire logic i_rx_start,
	input wire logic i_receiver_off,
	input wire logic i_rx_ok,
	input wire logic i_checksum_bad,
	input wire logic i_alignment_err,
	input wire logic i_rx_buffer_overrun,
	input wire logic i_dropped_frame,
	input wire logic i_rx_eval,
	input wire logic [1:0] i_rx_dst_kind,
	input wire logic i_rx_node_match,
	input wire logic i_rx_hash_hit,
	input wire logic i_rx_short,
	input wire logic i_rx_errored,
	output logic o_rx_accept,
	output logic o_rx_store
);
	//------------------------------------------------------------
	// Host bus decode
	//------------------------------------------------------------
	logic [7:0] irq_mask_reg;
	logic [7:0] data_config_reg;
	logic [7:0] tx_config_reg;
	logic [7:0] rx_config_reg;
	logic [7:0] tx_status_reg;
	logic [7:0] tx_status_next;
	logic [6:0] rx_status_reg;
	logic [6:0] rx_status_next;
	logic [6:0] gap_length_reg;
	logic [6:0] gap_part1_reg;
	logic [6:0] gap_part2_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	wire wr_en = i_cs & i_wr;
	wire rd_en = i_cs & i_rd;
	wire wr_rx_cfg = wr_en & (i_addr == emcs_pkg::ADDR_RX_CFG_STS);
	wire wr_tx_cfg = wr_en & (i_addr == emcs_pkg::ADDR_TX_CONFIG);
	wire wr_data_cfg = wr_en & (i_addr == emcs_pkg::ADDR_DATA_CONFIG);
	wire wr_irq_mask = wr_en & (i_addr == emcs_pkg::ADDR_IRQ_MASK);
	wire wr_gap1 = wr_en & (i_addr == emcs_pkg::ADDR_GAP_PART1);
	wire wr_gap2 = wr_en & (i_addr == emcs_pkg::ADDR_GAP_PART2);
	wire wr_gapl = wr_en & (i_addr == emcs_pkg::ADDR_GAP_LENGTH);

	// Read mux; 0CH reads status while writes go to config
	always_comb begin
		unique case (i_addr)
			emcs_pkg::ADDR_TX_STATUS: rdata_next = tx_status_reg;
			emcs_pkg::ADDR_RX_CFG_STS: rdata_next = {1'b0, rx_status_reg};
			emcs_pkg::ADDR_GAP_PART1: rdata_next = {1'b0, gap_part1_reg};
			emcs_pkg::ADDR_GAP_PART2: rdata_next = {1'b0, gap_part2_reg};
			emcs_pkg::ADDR_GAP_LENGTH: rdata_next = {1'b0, gap_length_reg};
			default: rdata_next = 8'h00;
		endcase
	end

	// Read data register, updated on each read strobe
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			rdata_reg <= 8'h00;
		end else if (rd_en) begin
			rdata_reg <= rdata_next;
		end
	end
	assign o_rdata = rdata_reg;

	//------------------------------------------------------------
	// Configuration registers
	//------------------------------------------------------------
	// Write-only control registers; reserved bits kept as zero
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			irq_mask_reg <= emcs_pkg::RST_IRQ_MASK;
			data_config_reg <= emcs_pkg::RST_DATA_CONFIG;
			tx_config_reg <= emcs_pkg::RST_TX_CONFIG;
			rx_config_reg <= emcs_pkg::RST_RX_CONFIG;
		end else begin
			if (wr_irq_mask) begin
				irq_mask_reg <= {1'b0, i_wdata[6:0]};
			end
			if (wr_data_cfg) begin
				data_config_reg <= i_wdata & 8'h81;
			end
			if (wr_tx_cfg) begin
				tx_config_reg <= i_wdata & 8'he7;
			end
			if (wr_rx_cfg) begin
				rx_config_reg <= {1'b0, i_wdata[6:0]};
			end
		end
	end

	// Gap registers, seven bits each, bit 7 reads zero
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			gap_length_reg <= emcs_pkg::RST_GAP_LENGTH;
			gap_part1_reg <= emcs_pkg::RST_GAP_PART1;
			gap_part2_reg <= emcs_pkg::RST_GAP_PART2;
		end else begin
			if (wr_gapl) begin
				gap_length_reg <= i_wdata[6:0];
			end
			if (wr_gap1) begin
				gap_part1_reg <= i_wdata[6:0];
			end
			if (wr_gap2) begin
				gap_part2_reg <= i_wdata[6:0];
			end
		end
	end
	assign o_gap_length = gap_length_reg;
	assign o_gap_part1 = gap_part1_reg;
	assign o_gap_part2 = gap_part2_reg;

	// Control fields driven to the datapath
	assign o_word_wide = data_config_reg[emcs_pkg::DC_WORD_WIDE];
	assign o_full_duplex = tx_config_reg[emcs_pkg::TC_FULL_DUPLEX];
	assign o_late_coll_retry = tx_config_reg[emcs_pkg::TC_LATE_COLL_RETRY];
	assign o_loopback_sel = tx_config_reg[emcs_pkg::TC_LOOPBACK_HI:emcs_pkg::TC_LOOPBACK_LO];
	assign o_mac_loopback = (o_loopback_sel == emcs_pkg::LOOP_MAC);
	assign o_phy_loopback = (o_loopback_sel == emcs_pkg::LOOP_PHY);
	wire dma_force_done = data_config_reg[emcs_pkg::DC_DMA_FORCE_DONE];
	assign o_dma_complete = i_dma_done | dma_force_done;

	//------------------------------------------------------------
	// Interrupt pin
	//------------------------------------------------------------
	logic mode_sync1_reg;
	logic mode_sync2_reg;
	logic irq_pin_reg;
	wire irq_polarity = rx_config_reg[emcs_pkg::RC_IRQ_POLARITY];
	wire irq_active = |(i_irq_status & irq_mask_reg[6:0]);
	// ISA-type hosts: polarity 1 is active high; others inverted
	wire irq_active_high = mode_sync2_reg ? irq_polarity : ~irq_polarity;

	// Host mode strap synchroniser and registered pin
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			mode_sync1_reg <= 1'b1;
			mode_sync2_reg <= 1'b1;
			irq_pin_reg <= 1'b0;
		end else begin
			mode_sync1_reg <= i_isa_mode;
			mode_sync2_reg <= mode_sync1_reg;
			irq_pin_reg <= ~(irq_active ^ irq_active_high);
		end
	end
	assign o_irq = irq_pin_reg;

	//------------------------------------------------------------
	// Transmit and receive status
	//------------------------------------------------------------
	// Cleared at frame start; a same-cycle event still sets
	always_comb begin
		tx_status_next = i_tx_start ? emcs_pkg::RST_STATUS : tx_status_reg;
		tx_status_next[emcs_pkg::TS_LATE_COLLISION] =
			tx_status_next[emcs_pkg::TS_LATE_COLLISION] | i_tx_late_collision;
		tx_status_next[emcs_pkg::TS_TX_GAVE_UP] =
			tx_status_next[emcs_pkg::TS_TX_GAVE_UP] | i_tx_gave_up;
		tx_status_next[emcs_pkg::TS_COLLIDED] =
			tx_status_next[emcs_pkg::TS_COLLIDED] | i_tx_collided;
		tx_status_next[emcs_pkg::TS_TX_OK] =
			tx_status_next[emcs_pkg::TS_TX_OK] | i_tx_ok;
	end

	// Receive conditions, bit 6 follows the receiver level
	always_comb begin
		rx_status_next = i_rx_start ? 7'h00 : rx_status_reg;
		rx_status_next[6] = i_receiver_off;
		rx_status_next[5] = rx_status_next[5] |
			(i_rx_eval & (i_rx_dst_kind != emcs_pkg::DST_UNICAST));
		rx_status_next[4] = rx_status_next[4] | i_dropped_frame;
		rx_status_next[3] = rx_status_next[3] | i_rx_buffer_overrun;
		rx_status_next[2] = rx_status_next[2] | i_alignment_err;
		rx_status_next[1] = rx_status_next[1] | i_checksum_bad;
		rx_status_next[0] = rx_status_next[0] | i_rx_ok;
	end

	// Status registers
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			tx_status_reg <= emcs_pkg::RST_STATUS;
			rx_status_reg <= 7'h00;
		end else begin
			tx_status_reg <= tx_status_next;
			rx_status_reg <= rx_status_next;
		end
	end

	//------------------------------------------------------------
	// Receive address filter
	//------------------------------------------------------------
	logic rx_accept_reg;
	logic rx_store_reg;
	wire check_only = rx_config_reg[emcs_pkg::RC_CHECK_ONLY];
	wire kind_uni = (i_rx_dst_kind == emcs_pkg::DST_UNICAST);
	wire kind_multi = (i_rx_dst_kind == emcs_pkg::DST_MULTICAST);
	wire kind_bcast = (i_rx_dst_kind == emcs_pkg::DST_BROADCAST);
	wire uni_ok = kind_uni & (i_rx_node_match |
		rx_config_reg[emcs_pkg::RC_ALL_UNICAST]);
	wire multi_ok = kind_multi & i_rx_hash_hit &
		rx_config_reg[emcs_pkg::RC_MULTICAST];
	wire bcast_ok = kind_bcast & rx_config_reg[emcs_pkg::RC_BROADCAST];
	wire short_ok = ~i_rx_short | rx_config_reg[emcs_pkg::RC_SHORT_FRAMES];
	wire err_ok = ~i_rx_errored | rx_config_reg[emcs_pkg::RC_SAVE_ERRORS];
	wire rx_pass = (uni_ok | multi_ok | bcast_ok) & short_ok & err_ok;

	// One-cycle verdict per evaluated frame
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			rx_accept_reg <= 1'b0;
			rx_store_reg <= 1'b0;
		end else begin
			rx_accept_reg <= i_rx_eval & rx_pass;
			rx_store_reg <= i_rx_eval & rx_pass & ~check_only;
		end
	end
	assign o_rx_accept = rx_accept_reg;
	assign o_rx_store = rx_store_reg;

	//------------------------------------------------------------
	// Transmit padding and FCS
	//------------------------------------------------------------
	emcs_pkg::emcs_tx_state_e st_reg;
	emcs_pkg::emcs_tx_state_e st_next;
	logic [5:0] cnt_reg;
	logic [31:0] crc_reg;
	logic [1:0] fcs_idx_reg;
	logic ov_reg;
	logic [7:0] od_reg;
	logic ol_reg;

	// Reflected CRC-32 over one byte
	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c ^ {24'h00_0000, d};
		for (int k = 0; k < 8; k++) begin
			r = r[0] ? ((r >> 1) ^ emcs_pkg::CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	wire pad_on = ~tx_config_reg[emcs_pkg::TC_PAD_DISABLE];
	wire fcs_on = ~tx_config_reg[emcs_pkg::TC_CRC_INHIBIT];
	wire adv = ~ov_reg | i_txo_ready;
	wire take = (st_reg == emcs_pkg::EMCS_TX_DATA) & adv & i_tx_valid;
	wire [5:0] cnt_inc = (cnt_reg == emcs_pkg::MIN_FRAME_BYTES) ? cnt_reg : cnt_reg + 6'h01;
	wire short_now = cnt_inc < emcs_pkg::MIN_FRAME_BYTES;
	wire need_pad = pad_on & short_now;
	wire [31:0] crc_fin = ~crc_reg;
	wire [7:0] fcs_byte = crc_fin[{fcs_idx_reg, 3'b000} +: 8];
	assign o_tx_ready = (st_reg == emcs_pkg::EMCS_TX_DATA) & adv;

	// Next state of the shaping sequencer
	always_comb begin
		st_next = st_reg;
		unique case (st_reg)
			emcs_pkg::EMCS_TX_DATA: begin
				if (take & i_tx_last) begin
					st_next = need_pad ? emcs_pkg::EMCS_TX_PAD :
						(fcs_on ? emcs_pkg::EMCS_TX_FCS : emcs_pkg::EMCS_TX_DATA);
				end
			end
			emcs_pkg::EMCS_TX_PAD: begin
				if (adv & ~short_now) begin
					st_next = fcs_on ? emcs_pkg::EMCS_TX_FCS : emcs_pkg::EMCS_TX_DATA;
				end
			end
			emcs_pkg::EMCS_TX_FCS: begin
				if (adv & (fcs_idx_reg == emcs_pkg::FCS_LAST_IDX)) begin
					st_next = emcs_pkg::EMCS_TX_DATA;
				end
			end
		endcase
	end

	// Byte count and CRC accumulation
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			st_reg <= emcs_pkg::EMCS_TX_DATA;
			cnt_reg <= 6'h00;
			crc_reg <= emcs_pkg::CRC_INIT;
			fcs_idx_reg <= 2'h0;
		end else begin
			st_reg <= st_next;
			if (take) begin
				cnt_reg <= cnt_inc;
				crc_reg <= crc_byte(crc_reg, i_tx_data);
			end else if ((st_reg == emcs_pkg::EMCS_TX_PAD) & adv) begin
				cnt_reg <= cnt_inc;
				crc_reg <= crc_byte(crc_reg, 8'h00);
			end else if ((st_reg == emcs_pkg::EMCS_TX_FCS) & adv) begin
				fcs_idx_reg <= fcs_idx_reg + 2'h1;
			end
			if (st_next == emcs_pkg::EMCS_TX_DATA && st_reg != emcs_pkg::EMCS_TX_DATA) begin
				cnt_reg <= 6'h00;
				crc_reg <= emcs_pkg::CRC_INIT;
				fcs_idx_reg <= 2'h0;
			end else if (take & i_tx_last & ~need_pad & ~fcs_on) begin
				cnt_reg <= 6'h00;
				crc_reg <= emcs_pkg::CRC_INIT;
			end
		end
	end

	// Output byte register toward the MAC
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			ov_reg <= 1'b0;
			od_reg <= 8'h00;
			ol_reg <= 1'b0;
		end else if (adv) begin
			ov_reg <= take | (st_reg != emcs_pkg::EMCS_TX_DATA);
			if (take) begin
				od_reg <= i_tx_data;
				ol_reg <= i_tx_last & ~need_pad & ~fcs_on;
			end else if (st_reg == emcs_pkg::EMCS_TX_PAD) begin
				od_reg <= 8'h00;
				ol_reg <= ~short_now & ~fcs_on;
			end else begin
				od_reg <= fcs_byte;
				ol_reg <= (fcs_idx_reg == emcs_pkg::FCS_LAST_IDX);
			end
		end
	end
	assign o_txo_valid = ov_reg;
	assign o_txo_data = od_reg;
	assign o_txo_last = ol_reg;

	//------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------
	sequence fcs_beat;
		st_reg == emcs_pkg::EMCS_TX_FCS && adv;
	endsequence
	sequence fcs_done;
		##1 o_txo_valid && o_txo_last;
	endsequence

	irq_reset_off_a: assert property (@(posedge i_clk)
		$rose(i_resetn) |-> irq_mask_reg == 8'h00)
		else $error("interrupt enables not cleared by reset");
	irq_gate_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(irq_active_high && $past(i_resetn)) |-> ##1 (o_irq == $past(irq_active)))
		else $error("interrupt pin not following enabled flags");
	dma_force_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		$past(wr_data_cfg && i_wdata[7]) |-> o_dma_complete)
		else $error("forced DMA completion missing");
	pad_min_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(st_reg == emcs_pkg::EMCS_TX_PAD && adv && !short_now && fcs_on)
		|=> st_reg == emcs_pkg::EMCS_TX_FCS && cnt_reg == emcs_pkg::MIN_FRAME_BYTES)
		else $error("padding ended short of minimum frame");
	pad_zero_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(st_reg == emcs_pkg::EMCS_TX_PAD && adv) |=> o_txo_valid && o_txo_data == 8'h00)
		else $error("pad byte not zero");
	fcs_four_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(fcs_beat and (fcs_idx_reg == emcs_pkg::FCS_LAST_IDX)) |-> fcs_done)
		else $error("FCS did not end after four bytes");
	abort_flag_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		i_tx_gave_up |=> tx_status_reg[3] ##1 (tx_status_reg[3] || $past(i_tx_start)))
		else $error("abort flag lost");
	coll_flag_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_tx_collided && i_tx_start) |=> tx_status_reg[2] && !tx_status_reg[3] ||
		$past(i_tx_gave_up))
		else $error("collision flag lost on start");
	monitor_nostore_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_rx_store |-> o_rx_accept && !$past(check_only))
		else $error("frame stored in check-only mode");
	multi_hash_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_rx_eval && kind_multi && !i_rx_hash_hit) |=> !o_rx_accept)
		else $error("multicast accepted without hash hit");
	share_addr_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(rd_en && i_addr == emcs_pkg::ADDR_RX_CFG_STS) |=> o_rdata == {1'b0, $past(rx_status_reg)})
		else $error("offset 0CH read did not return status");
	gap_write_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		wr_gapl |=> o_gap_length == $past(i_wdata[6:0]))
		else $error("gap length write lost");
endmodule

// ==== verification/emcs_host.sv ====
// Host bus model that drives the strobed register bus of the MAC block
`timescale 1ns/1ps
module emcs_host (
	input wire logic i_clk,
	input wire logic [7:0] i_rdata,
	output logic o_cs,
	output logic o_wr,
	output logic o_rd,
	output logic [4:0] o_addr,
	output logic [7:0] o_wdata
);
	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	// Idle bus at time zero
	initial begin
		o_cs = 1'h0;
		o_wr = 1'h0;
		o_rd = 1'h0;
		o_addr = 5'h00;
		o_wdata = 8'h00;
	end

	// One strobe taken at a rising edge; released lines show inverted leftovers
	task cyc(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
		@(negedge i_clk);
		o_cs = 1'h1;
		o_wr = w;
		o_rd = !w;
		o_addr = a;
		o_wdata = d;
		@(negedge i_clk);
		o_cs = 1'h0;
		o_wr = 1'h0;
		o_rd = 1'h0;
		o_addr = ~a;
		o_wdata = ~d;
		q = i_rdata;
	endtask
endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the MAC configuration and status block
`timescale 1ns/1ps
module tb;
	logic i_clk = 0, i_resetn = 0, i_cs, i_wr, i_rd, i_isa_mode = 1, i_dma_done = 0;
	logic [4:0] i_addr;
	logic [7:0] i_wdata, o_rdata, i_tx_data = 0, o_txo_data, q, v, pl[64];
	logic [6:0] i_irq_status = 0, o_gap_length, o_gap_part1, o_gap_part2;
	logic [1:0] o_loopback_sel, i_rx_dst_kind = 0;
	logic o_irq, o_dma_complete, o_word_wide, o_full_duplex, o_late_coll_retry;
	logic o_mac_loopback, o_phy_loopback, o_tx_ready, o_txo_valid, o_txo_last;
	logic o_rx_accept, o_rx_store, i_txo_ready = 1, i_tx_valid = 0, i_tx_last = 0;
	logic i_tx_start = 0, i_tx_ok = 0, i_tx_collided = 0, i_tx_gave_up = 0;
	logic i_tx_late_collision = 0, i_rx_start = 0, i_receiver_off = 0, i_rx_ok = 0;
	logic i_checksum_bad = 0, i_alignment_err = 0, i_rx_buffer_overrun = 0;
	logic i_dropped_frame = 0, i_rx_eval = 0, i_rx_node_match = 0, i_rx_hash_hit = 0;
	logic i_rx_short = 0, i_rx_errored = 0, act, ah, ex;
	logic [7:0] ob[128];
	logic [31:0] c;
	logic [31:0] seed = 32'h99cc_31b2;
	int fails = 0, samples_checked = 0, n, cnt, bad, e;
	logic [4:0] gadr[3] = '{emcs_pkg::ADDR_GAP_LENGTH, emcs_pkg::ADDR_GAP_PART1,
		emcs_pkg::ADDR_GAP_PART2};
	logic [7:0] grst[3] = '{8'h15, 8'h0c, 8'h12};

	// Clock at 200 MHz
	always #2.5 i_clk = ~i_clk;

	emcs_top uut (.*);
	emcs_host h (.i_clk(i_clk), .i_rdata(o_rdata), .o_cs(i_cs), .o_wr(i_wr), .o_rd(i_rd),
		.o_addr(i_addr), .o_wdata(i_wdata));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Reflected CRC-32 step over one byte, for the expected FCS
	function logic [31:0] crc32b(input logic [31:0] cc, input logic [7:0] d);
		cc = cc ^ {24'h00_0000, d};
		for (int b = 0; b < 8; b++) cc = cc[0] ? ((cc >> 1) ^ 32'hedb8_8320) : (cc >> 1);
		return cc;
	endfunction

	task chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got %h want %h", $time, got, exp);
		end
	endtask

	task wr(input logic [4:0] a, input logic [7:0] d);
		h.cyc(1'h1, a, d, q);
	endtask

	task rd(input logic [4:0] a);
		h.cyc(1'h0, a, 8'h00, q);
	endtask

	// Byte stream into the shaper
	task send();
		for (int i = 0; i < n; i++) begin
			@(negedge i_clk);
			i_tx_valid = 1;
			i_tx_data = pl[i];
			i_tx_last = (i == n - 1);
			while (!o_tx_ready) @(negedge i_clk);
		end
		@(negedge i_clk);
		i_tx_valid = 0;
	endtask

	// Shaped stream out: payload, then zero pad when enabled
	task collect(input logic pad);
		cnt = 0;
		bad = 0;
		for (int k = 0; k < 300; k++) begin
			@(negedge i_clk);
			if (o_txo_valid) begin
				if (cnt < 128) ob[cnt] = o_txo_data;
				if (cnt < n) begin
					if (o_txo_data !== pl[cnt]) bad++;
				end else if (pad && cnt < 60 && o_txo_data !== 8'h00) bad++;
				cnt++;
				if (o_txo_last) break;
			end
		end
	endtask

	task results();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Watchdog
	initial begin
		#200us;
		fails++;
		results();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(negedge i_clk);
		i_resetn = 1;
		i_irq_status = 7'h7f;
		for (int k = 0; k < 3; k++) begin
			rd(gadr[k]);
			chk(q, grst[k]);
			v = rnd();
			wr(gadr[k], v);
			rd(gadr[k]);
			chk(q, v & 8'h7f);
		end
		chk(o_irq, 0);
		rd(5'h1f);
		chk(q, 8'h00);
		wr(emcs_pkg::ADDR_TX_STATUS, 8'hff);
		rd(emcs_pkg::ADDR_TX_STATUS);
		chk(q, 8'h00);
		$display("registers done");
		for (int k = 0; k < 8; k++) begin
			v = rnd();
			v[2:1] = k[1:0];
			wr(emcs_pkg::ADDR_TX_CONFIG, v);
			chk({o_full_duplex, o_late_coll_retry, o_loopback_sel, o_mac_loopback,
				o_phy_loopback}, {v[7], v[5], v[2:1], v[2:1] == 1, v[2:1] == 2});
			v = rnd();
			wr(emcs_pkg::ADDR_DATA_CONFIG, v);
			chk({o_word_wide, o_dma_complete}, {v[0], v[7]});
		end
		$display("config done");
		for (int k = 0; k < 12; k++) begin
			v = rnd();
			i_isa_mode = v[7];
			i_irq_status = v[6:0];
			v = rnd();
			wr(emcs_pkg::ADDR_IRQ_MASK, v);
			act = |(i_irq_status & v[6:0]);
			v = rnd() & 8'h7f;
			wr(emcs_pkg::ADDR_RX_CFG_STS, v);
			repeat (3) @(negedge i_clk);
			ah = i_isa_mode ? v[6] : ~v[6];
			chk(o_irq, act ? ah : !ah);
			for (int j = 0; j < 4; j++) begin
				e = rnd();
				i_rx_dst_kind = e[1:0] % 3;
				{i_rx_errored, i_rx_short, i_rx_hash_hit, i_rx_node_match} = e[5:2];
				ex = ((e[1:0] % 3 == 0) & (e[2] | v[4]) | (e[1:0] % 3 == 1) & e[3] & v[3]
					| (e[1:0] % 3 == 2) & v[2]) & (!e[4] | v[1]) & (!e[5] | v[0]);
				i_rx_eval = 1;
				@(negedge i_clk);
				i_rx_eval = 0;
				chk({o_rx_accept, o_rx_store}, {ex, ex & !v[5]});
			end
		end
		$display("irq and filter done");
		// Events land in the same cycle as the clearing start: set must win
		{i_tx_start, i_rx_start, i_receiver_off} = 3'h7;
		{i_tx_ok, i_tx_collided, i_tx_gave_up, i_tx_late_collision} = 4'hf;
		{i_rx_ok, i_checksum_bad, i_alignment_err, i_rx_buffer_overrun, i_dropped_frame} = 5'h1f;
		@(negedge i_clk);
		{i_tx_start, i_rx_start} = 2'h0;
		{i_tx_ok, i_tx_collided, i_tx_gave_up, i_tx_late_collision} = 4'h0;
		{i_rx_ok, i_checksum_bad, i_alignment_err, i_rx_buffer_overrun, i_dropped_frame} = 5'h00;
		rd(emcs_pkg::ADDR_TX_STATUS);
		chk(q, 8'h8d);
		rd(emcs_pkg::ADDR_RX_CFG_STS);
		chk(q, 8'h5f);
		$display("status done");
		for (int k = 0; k < 5; k++) begin
			v = (k == 4) ? 8'h41 : (k == 3) ? 8'h40 : 8'h00;
			n = (k == 1) ? 60 : (k == 2) ? 59 : 1 + rnd() % 40;
			for (int i = 0; i < 64; i++) pl[i] = rnd();
			wr(emcs_pkg::ADDR_TX_CONFIG, v);
			fork
				send();
				collect(!v[6]);
			join
			e = ((!v[6] && n < 60) ? 60 : n) + (v[0] ? 0 : 4);
			chk(cnt, e);
			chk(bad, 0);
			if (!v[0] && cnt == e) begin
				c = 32'hffff_ffff;
				for (int i = 0; i < e - 4; i++) c = crc32b(c, ob[i]);
				c = ~c;
				for (int i = 0; i < 4; i++) chk(ob[e - 4 + i], c[8 * i +: 8]);
			end
		end
		$display("frames done");
		results();
	end
endmodule
